/* gige_phy_mgmt_regs_9_to_15_bench.sv */
module gige_phy_mgmt_regs_9_to_15_bench
  import mgmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] ALL = 16'hffff;
  logic clk, rstn, irq;
  logic [CSR_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic halfDuplexStrap, msFaultEvent, msMaster, localRxOk, remoteRxOk;
  logic partner_gig_full_duplex, partner_gig_half_duplex;
  logic receivingIdle, transmit_mode_indication, symbolError;
  logic [DATA_W-1:0] extRdData, extWrData;
  logic advertFull, advertHalf, extWrStb, extRdStb, extPage;
  logic [EXT_ADDR_W-1:0] extAddr;
  int errTotal, cmpCount, ackCnt, n;
  logic [65:0] rdQ[$]; // Read notes: resp, mask, data
  logic [1:0] bQ[$]; // Write response notes
  logic [25:0] xQ[$]; // Strobe notes: read, page, addr, data
  logic [65:0] note;
  logic [25:0] xn;
  logic [15:0] v, c, d, r;

  mgmt_link_if lnk();
  // Both ends joined across the link
  mgmt_dev_regs i_mgmt_dev_regs (.link(lnk.device), .*);
  mgmt_host_ctrl i_mgmt_host_ctrl (.link(lnk.host), .*);
  mgmt_link_props i_mgmt_link_props (.clk(clk), .rstn(rstn),
    .req(lnk.req), .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata),
    .ack(lnk.ack), .rdata(lnk.rdata));

  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic endSim;
    if (errTotal == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Master write: address and data offered together, response awaited
  task automatic axW(logic [3:0] a, logic [31:0] dt, logic [1:0] rs);
    bQ.push_back(rs);
    s_axi_awaddr <= a;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axR(logic [3:0] a, logic [65:0] nt);
    rdQ.push_back(nt);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  // One device access through the command word; waits for its answer
  task automatic dev(logic [4:0] a, logic w, logic [15:0] dt);
    int t;
    t = ackCnt + 1;
    axW(CSR_CMD, {dt, 7'h00, w, 3'h0, a}, AXI_OKAY);
    while (ackCnt < t) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  // Device read, result checked through the status word
  task automatic rd(logic [4:0] a, logic [15:0] e, logic [15:0] m);
    dev(a, 1'b0, 16'h0000);
    axR(CSR_STATUS, {AXI_OKAY, m, 16'h0001, e, 16'h0000});
  endtask

  // Link answers counted so a short pulse is never missed
  always @(posedge clk) begin
    if (lnk.ack === 1'b1) ackCnt++;
  end

  // Result watcher: oldest note against each response that appears
  always @(posedge clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      note = rdQ.pop_front();
      chk("rdata", s_axi_rdata & note[63:32], note[31:0]);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, note[65:64]});
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1)
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, bQ.pop_front()});
    if (extWrStb === 1'b1 || extRdStb === 1'b1) begin
      xn = xQ.pop_front();
      chk("ext", {6'h0, extRdStb, extPage, extAddr,
        extRdStb ? 16'h0000 : extWrData}, {6'h0, xn});
    end
  end

  // Hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errTotal++;
    endSim();
  end

  initial begin
    void'($urandom(6782));
    rstn <= 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b000;
    {s_axi_arvalid, s_axi_rready, msFaultEvent, msMaster} <= 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= '0;
    s_axi_wstrb <= 4'hf;
    halfDuplexStrap <= 1'b1; // Strap high so half-duplex resets set
    {localRxOk, remoteRxOk, partner_gig_full_duplex} <= 3'b000;
    partner_gig_half_duplex <= 1'b0;
    {receivingIdle, transmit_mode_indication, symbolError} <= 3'b000;
    extRdData <= 16'h0000;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // Reset values of every register in the window
    rd(REG_GIG_CTRL, 16'h0300, 16'h03ff);
    rd(REG_GIG_STAT, 16'h0000, ALL);
    rd(REG_EXT_CTRL, 16'h0000, ALL);
    rd(REG_EXT_WDATA, 16'h0000, ALL);
    rd(REG_EXT_RDATA, 16'h0000, ALL);
    rd(REG_EXT_STAT, 16'h3000, ALL);
    // Advert bits, reserved bits written with ones
    for (int i = 0; i < 3; i++) begin
      v = 16'($urandom) | 16'h00ff;
      dev(REG_GIG_CTRL, 1'b1, v);
      rd(REG_GIG_CTRL, v & 16'h0300, 16'h03ff);
      chk("advert", {30'h0, advertFull, advertHalf}, {30'h0, v[9:8]});
    end
    // Mirrored status levels
    for (int i = 0; i < 3; i++) begin
      v = 16'($urandom);
      {msMaster, localRxOk, remoteRxOk, partner_gig_full_duplex,
        partner_gig_half_duplex} <= v[4:0];
      repeat (2) @(posedge clk);
      rd(REG_GIG_STAT, {1'b0, v[4:0], 10'h0}, ALL);
    end
    // Fault latches, then clears once read
    msFaultEvent <= 1'b1;
    @(posedge clk);
    msFaultEvent <= 1'b0;
    repeat (3) @(posedge clk);
    rd(REG_GIG_STAT, 16'h8000, 16'h8000);
    rd(REG_GIG_STAT, 16'h0000, 16'h8000);
    // Idle errors: unqualified periods first, then a counted burst
    for (int k = 0; k < 2; k++) begin
      n = k ? 300 : $urandom_range(40, 1);
      {receivingIdle, transmit_mode_indication, symbolError} <= 3'b101;
      repeat (5) @(posedge clk);
      {receivingIdle, transmit_mode_indication, symbolError} <= 3'b011;
      repeat (5) @(posedge clk);
      {receivingIdle, transmit_mode_indication, symbolError} <= 3'b111;
      repeat (n) @(posedge clk);
      {receivingIdle, transmit_mode_indication, symbolError} <= 3'b000;
      rd(REG_GIG_STAT, 16'(n > 255 ? 255 : n), 16'h00ff);
      rd(REG_GIG_STAT, 16'h0000, 16'h00ff);
    end
    // Extended window: reads and writes alternate
    for (int i = 0; i < 4; i++) begin
      c = 16'($urandom);
      c[15] = i[0];
      d = 16'($urandom);
      extRdData <= 16'($urandom);
      if (!c[15]) xQ.push_back({1'b1, c[8], c[7:0], 16'h0000});
      dev(REG_EXT_CTRL, 1'b1, c);
      rd(REG_EXT_CTRL, c, ALL);
      if (c[15]) begin
        xQ.push_back({1'b0, c[8], c[7:0], d});
        dev(REG_EXT_WDATA, 1'b1, d);
        rd(REG_EXT_WDATA, d, ALL);
      end else begin
        r = extRdData;
        extRdData <= ~r; // Stale value must not leak in
        rd(REG_EXT_RDATA, r, ALL);
      end
    end
    // Writes to read-only places are dropped; an unmapped place reads zero
    dev(REG_EXT_RDATA, 1'b1, ~r);
    dev(REG_EXT_STAT, 1'b1, 16'h0000);
    dev(REG_GIG_STAT, 1'b1, ALL);
    rd(REG_EXT_RDATA, r, ALL);
    rd(REG_EXT_STAT, 16'h3000, ALL);
    rd(REG_GIG_STAT, 16'h0000, 16'h83ff);
    rd(5'h0e, 16'h0000, ALL);
    // Interrupt unmask, clear, re-raise, mask
    axW(CSR_IRQ_MASK, 32'h1, AXI_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    axW(CSR_IRQ_STAT, 32'h1, AXI_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    dev(REG_EXT_STAT, 1'b0, 16'h0000);
    chk("irq", {31'h0, irq}, 32'h1);
    axW(CSR_IRQ_MASK, 32'h0, AXI_OKAY);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    axR(CSR_IRQ_STAT, {AXI_OKAY, 32'h1, 32'h1});
    axW(CSR_STATUS, 32'h0, AXI_SLVERR);
    axR(4'h2, {AXI_SLVERR, 32'hffffffff, 32'h0});
    // Second reset with the strap low: half-duplex advert starts clear
    halfDuplexStrap <= 1'b0;
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    rd(REG_GIG_CTRL, 16'h0200, 16'h03ff);
    chk("advert", {30'h0, advertFull, advertHalf}, 32'h2);
    repeat (4) @(posedge clk);
    endSim();
  end
endmodule

/* mgmt_dev_regs.sv */
// Functional notes
// - Full-duplex advert bit, read/write, resets one
// - Half-duplex advert bit resets from strap
// - Control reserved bits ignored, read zero
// - Configuration fault latches high, clears on read
// - Resolved role bit: master one
// - Local receiver health mirrored
// - Remote receiver health mirrored
// - Partner gigabit full/half abilities mirrored
// - Idle error count, qualified, clears on read
// - Count one per errored symbol period
// - Extended access direction bit, write one
// - Extended page bit plus reserved read/write
// - Extended register address field
// - Write data goes to extended register
// - Read data shows extended register value
// - 1000BASE-X abilities always read zero
// - Twisted-pair abilities read one, rest zero
module mgmt_dev_regs
  import mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  mgmt_link_if.device link,
  input wire logic halfDuplexStrap, // Level sampled after reset release
  input wire logic msFaultEvent, // Configuration fault seen
  input wire logic msMaster, // Role resolved to master
  input wire logic localRxOk,
  input wire logic remoteRxOk,
  input wire logic partner_gig_full_duplex,
  input wire logic partner_gig_half_duplex,
  input wire logic receivingIdle, // Receiver sees idles
  input wire logic transmit_mode_indication, // High in normal sending
  input wire logic symbolError, // One symbol period flagged in error
  input wire logic [DATA_W-1:0] extRdData, // Answer to extRdStb
  output logic advertFull,
  output logic advertHalf,
  output logic extWrStb, // One-cycle extended write
  output logic extRdStb, // One-cycle extended read
  output logic extPage,
  output logic [EXT_ADDR_W-1:0] extAddr,
  output logic [DATA_W-1:0] extWrData
);

  logic ack_r; // Answer pulse
  logic [DATA_W-1:0] rdata_r; // Answer data
  logic strapDone_r; // Strap has been taken
  logic advFull_r;
  logic advHalf_r;
  logic msFault_r; // Sticky fault
  logic [4:0] mirror_r; // Registered status mirrors, role bit first
  logic [IDLE_CNT_W-1:0] idleCnt_r;
  logic [DATA_W-1:0] extCtrl_r;
  logic [DATA_W-1:0] extWdata_r;
  logic [DATA_W-1:0] extRdata_r;
  logic extWrStb_r;
  logic extRdStb_r;
  logic access; // Request taken this cycle
  logic wrAcc; // Write taken this cycle
  logic rdStat; // Status word read this cycle
  logic countIdle; // Idle error qualifies
  logic [DATA_W-1:0] rdMux; // Selected read word

  // A request is taken once; ack blocks a second take of the same one
  assign access = link.req && !ack_r;
  assign wrAcc = access && link.we;
  assign rdStat = access && !link.we && link.addr == REG_GIG_STAT;
  assign countIdle = symbolError && receivingIdle &&
                     transmit_mode_indication;

  // Status word assembly, shared by the read mux
  function automatic logic [DATA_W-1:0] statWord(
    input logic fault,
    input logic [4:0] mir,
    input logic [IDLE_CNT_W-1:0] cnt
  );
    logic [DATA_W-1:0] w;
    w = '0;
    w[B_MS_FAULT] = fault;
    w[B_MS_MASTER] = mir[4];
    w[B_LOC_OK] = mir[3];
    w[B_REM_OK] = mir[2];
    w[B_LP_FULL] = mir[1];
    w[B_LP_HALF] = mir[0];
    w[IDLE_CNT_W-1:0] = cnt;
    return w;
  endfunction

  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rdMux = '0;
    unique case (link.addr)
      REG_GIG_CTRL: begin
        rdMux[B_ADV_FULL] = advFull_r;
        rdMux[B_ADV_HALF] = advHalf_r;
      end
      REG_GIG_STAT: rdMux = statWord(msFault_r, mirror_r, idleCnt_r);
      REG_EXT_CTRL: rdMux = extCtrl_r;
      REG_EXT_WDATA: rdMux = extWdata_r;
      REG_EXT_RDATA: rdMux = extRdata_r;
      REG_EXT_STAT: rdMux = EXT_STAT_VALUE;
      default: rdMux = '0;
    endcase
  end

  // Answer: ack one cycle after the request is seen, data with it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r <= access;
      if (access && !link.we) begin
        rdata_r <= rdMux;
      end
    end
  end

  // Advertisement bits; the strap is taken on the first edge after
  // release because an async reset must only load constants
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      strapDone_r <= 1'b0;
      advFull_r <= ADV_FULL_RST;
      advHalf_r <= 1'b0;
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      advHalf_r <= halfDuplexStrap;
    end else if (wrAcc && link.addr == REG_GIG_CTRL) begin
      advFull_r <= link.wdata[B_ADV_FULL];
      advHalf_r <= link.wdata[B_ADV_HALF];
      // Low bits are dropped on purpose
    end
  end

  // Sticky fault: a new fault in the read cycle survives the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msFault_r <= 1'b0;
    end else if (msFaultEvent) begin
      msFault_r <= 1'b1;
    end else if (rdStat) begin
      msFault_r <= 1'b0;
    end
  end

  // Live mirrors, registered so they read zero out of reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mirror_r <= '0;
    end else begin
      mirror_r <= {msMaster, localRxOk, remoteRxOk,
                   partner_gig_full_duplex,
                   partner_gig_half_duplex};
    end
  end

  // Idle error counter; saturates so a long burst is not hidden by wrap
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idleCnt_r <= '0;
    end else if (rdStat) begin
      idleCnt_r <= countIdle ? IDLE_CNT_W'(1) : '0;
    end else if (countIdle && idleCnt_r != IDLE_CNT_MAX) begin
      idleCnt_r <= idleCnt_r + IDLE_CNT_W'(1);
    end
  end

  // Extended access control and write data, fully read/write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extCtrl_r <= EXT_CTRL_RST;
      extWdata_r <= EXT_DATA_RST;
    end else if (wrAcc) begin
      if (link.addr == REG_EXT_CTRL) begin
        extCtrl_r <= link.wdata;
      end
      if (link.addr == REG_EXT_WDATA) begin
        extWdata_r <= link.wdata;
      end
    end
  end

  // Strobes toward the extended bank
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extWrStb_r <= 1'b0;
      extRdStb_r <= 1'b0;
    end else begin
      extWrStb_r <= wrAcc && link.addr == REG_EXT_WDATA &&
                    extCtrl_r[B_EXT_WRITE];
      extRdStb_r <= wrAcc && link.addr == REG_EXT_CTRL &&
                    !link.wdata[B_EXT_WRITE];
    end
  end

  // Read data is caught while the read strobe stands
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      extRdata_r <= EXT_DATA_RST;
    end else if (extRdStb_r) begin
      extRdata_r <= extRdData;
    end
  end

  // All outputs straight from flops
  assign link.ack = ack_r;
  assign link.rdata = rdata_r;
  assign advertFull = advFull_r;
  assign advertHalf = advHalf_r;
  assign extWrStb = extWrStb_r;
  assign extRdStb = extRdStb_r;
  assign extPage = extCtrl_r[B_EXT_PAGE];
  assign extAddr = extCtrl_r[EXT_ADDR_W-1:0];
  assign extWrData = extWdata_r;

endmodule

/* mgmt_host_ctrl.sv */
module mgmt_host_ctrl
  import mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  mgmt_link_if.host link,
  input wire logic [CSR_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CSR_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } state_t;

  state_t state_r;
  logic awReady_r;
  logic bValid_r;
  logic [1:0] bResp_r;
  logic arReady_r;
  logic rValid_r;
  logic [31:0] rData_r;
  logic [1:0] rResp_r;
  logic req_r;
  logic we_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [DATA_W-1:0] result_r; // Last read answer
  logic [IRQ_W-1:0] irqStat_r;
  logic [IRQ_W-1:0] irqMask_r;
  logic irq_r;
  logic wrTake; // Write address and data taken
  logic rdTake; // Read address taken
  logic cmdGo; // Command register written
  logic done; // Device answered
  logic [DATA_W-1:0] cmdData; // Link write word taken from the command

  // Address and data are taken together, one write at a time
  assign wrTake = awReady_r && s_axi_awvalid && s_axi_wvalid;
  assign rdTake = arReady_r && s_axi_arvalid;
  assign cmdGo = wrTake && s_axi_awaddr == CSR_CMD && state_r == ST_IDLE;
  assign done = state_r == ST_WAIT && link.ack;

  // Reserved advert bits never reach the link, whatever software sends
  always_comb begin
    cmdData = s_axi_wdata[CMD_DATA_LSB +: DATA_W];
    if (s_axi_wdata[ADDR_W-1:0] == REG_GIG_CTRL) begin
      cmdData[B_ADV_HALF-1:0] = '0;
    end
  end

  // Write channel handshakes; ready is a single-cycle pulse
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awReady_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= AXI_OKAY;
    end else begin
      awReady_r <= s_axi_awvalid && s_axi_wvalid && !awReady_r && !bValid_r;
      if (wrTake) begin
        bValid_r <= 1'b1;
        bResp_r <= s_axi_awaddr == CSR_STATUS ? AXI_SLVERR : AXI_OKAY;
      end else if (s_axi_bready) begin
        bValid_r <= 1'b0;
      end
    end
  end

  // Read channel; unmapped offsets answer with an error
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arReady_r <= 1'b0;
      rValid_r <= 1'b0;
      rData_r <= '0;
      rResp_r <= AXI_OKAY;
    end else begin
      arReady_r <= s_axi_arvalid && !arReady_r && !rValid_r;
      if (rdTake) begin
        rValid_r <= 1'b1;
        rResp_r <= AXI_OKAY;
        unique case (s_axi_araddr)
          CSR_CMD: rData_r <= {wdata_r, 7'h00, we_r, 3'h0, addr_r};
          CSR_STATUS: rData_r <= {result_r, 15'h0000, state_r == ST_WAIT};
          CSR_IRQ_STAT: rData_r <= 32'(irqStat_r);
          CSR_IRQ_MASK: rData_r <= 32'(irqMask_r);
          default: begin
            rData_r <= '0;
            rResp_r <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        rValid_r <= 1'b0;
      end
    end
  end

  // Link sequencer: a command while busy is dropped, so software must
  // poll busy or wait for the done interrupt before the next one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= '0;
      wdata_r <= '0;
      result_r <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: if (cmdGo) begin
          req_r <= 1'b1;
          we_r <= s_axi_wdata[CMD_WRITE_BIT];
          addr_r <= s_axi_wdata[ADDR_W-1:0];
          wdata_r <= cmdData;
          state_r <= ST_WAIT;
        end
        ST_WAIT: if (link.ack) begin
          req_r <= 1'b0;
          if (!we_r) begin
            result_r <= link.rdata;
          end
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Interrupt: done is sticky, write one clears, set wins
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStat_r <= '0;
      irqMask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      if (wrTake && s_axi_awaddr == CSR_IRQ_MASK) begin
        irqMask_r <= s_axi_wdata[IRQ_W-1:0];
      end
      if (done) begin
        irqStat_r[IRQ_DONE_BIT] <= 1'b1;
      end else if (wrTake && s_axi_awaddr == CSR_IRQ_STAT) begin
        irqStat_r <= irqStat_r & ~s_axi_wdata[IRQ_W-1:0];
      end
      irq_r <= |(irqStat_r & irqMask_r);
    end
  end

  assign s_axi_awready = awReady_r;
  assign s_axi_wready = awReady_r;
  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_arready = arReady_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;
  assign irq = irq_r;
  assign link.req = req_r;
  assign link.we = we_r;
  assign link.addr = addr_r;
  assign link.wdata = wdata_r;

endmodule

/* mgmt_link_if.sv */
interface mgmt_link_if;
  import mgmt_pkg::*;
  logic req; // Access request, held until ack
  logic we; // 1 = write, 0 = read
  logic [ADDR_W-1:0] addr; // Register offset
  logic [DATA_W-1:0] wdata; // Write data
  logic ack; // One-cycle answer from the device
  logic [DATA_W-1:0] rdata; // Read data, valid with ack

  modport host (output req, output we, output addr, output wdata,
                input ack, input rdata);
  modport device (input req, input we, input addr, input wdata,
                  output ack, output rdata);
endinterface

/* mgmt_link_props.sv */
module mgmt_link_props
  import mgmt_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic req,
  input wire logic we,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic ack,
  input wire logic [DATA_W-1:0] rdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Read or write taken at this edge
  sequence rd_s(a);
    req && !we && !ack && addr == a;
  endsequence
  sequence wr_s(a);
    req && we && !ack && addr == a;
  endsequence

  logic [1:0] adv_r; // Last advert bits written
  logic advOk_r; // Advert shadow valid, strap value unknown here
  logic [DATA_W-1:0] ctl_r; // Shadow of the access control word
  logic [DATA_W-1:0] wd_r; // Shadow of the write data word

  // Advert shadow follows taken writes of the control word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      advOk_r <= 1'b0;
      adv_r <= 2'b00;
    end else if (req && we && !ack && addr == REG_GIG_CTRL) begin
      advOk_r <= 1'b1;
      adv_r <= wdata[9:8];
    end
  end

  // Extended window shadows, reset to zero like the registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctl_r <= 16'h0000;
      wd_r <= 16'h0000;
    end else if (req && we && !ack) begin
      if (addr == REG_EXT_CTRL) ctl_r <= wdata;
      if (addr == REG_EXT_WDATA) wd_r <= wdata;
    end
  end

  req_hold_a: assert property (req && !ack |=> req && $stable({we, addr}))
    else $error("request dropped or changed before answer");
  ack_once_a: assert property (req && !ack |=> ack ##1 !ack)
    else $error("answer not a single pulse after take");
  adv_back_a: assert property (
    rd_s(REG_GIG_CTRL) ##0 advOk_r |=> rdata[9:8] == adv_r)
    else $error("advert bits differ from last write");
  ctl_rsv_a: assert property (
    rd_s(REG_GIG_CTRL) |=> rdata[7:0] == 8'h00)
    else $error("reserved control bits not zero");
  ctl_zero_a: assert property (
    wr_s(REG_GIG_CTRL) |-> wdata[7:0] == 8'h00)
    else $error("reserved control bits sent non-zero");
  stat_rsv_a: assert property (
    rd_s(REG_GIG_STAT) |=> rdata[9:8] == 2'b00)
    else $error("reserved status bits not zero");
  ext_stat_a: assert property (
    rd_s(REG_EXT_STAT) |=> rdata == 16'h3000)
    else $error("ability word wrong");
  ext_ctrl_a: assert property (
    rd_s(REG_EXT_CTRL) |=> rdata == ctl_r)
    else $error("access control readback wrong");
  ext_wdata_a: assert property (
    rd_s(REG_EXT_WDATA) |=> rdata == wd_r)
    else $error("write data readback wrong");
endmodule

/* mgmt_pkg.sv */
package mgmt_pkg;
  // Management access widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam int EXT_ADDR_W = 8;
  localparam int IDLE_CNT_W = 8;

  // Device register offsets
  localparam logic [ADDR_W-1:0] REG_GIG_CTRL = 5'h09;
  localparam logic [ADDR_W-1:0] REG_GIG_STAT = 5'h0a;
  localparam logic [ADDR_W-1:0] REG_EXT_CTRL = 5'h0b;
  localparam logic [ADDR_W-1:0] REG_EXT_WDATA = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_EXT_RDATA = 5'h0d;
  localparam logic [ADDR_W-1:0] REG_EXT_STAT = 5'h0f;

  // Field positions of the gigabit control and status words
  localparam int B_ADV_FULL = 9;
  localparam int B_ADV_HALF = 8;
  localparam int B_MS_FAULT = 15;
  localparam int B_MS_MASTER = 14;
  localparam int B_LOC_OK = 13;
  localparam int B_REM_OK = 12;
  localparam int B_LP_FULL = 11;
  localparam int B_LP_HALF = 10;

  // Field positions of the extended access control word
  localparam int B_EXT_WRITE = 15;
  localparam int B_EXT_PAGE = 8;

  // Reset and fixed values
  localparam logic ADV_FULL_RST = 1'b1;
  localparam logic [DATA_W-1:0] EXT_CTRL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] EXT_DATA_RST = 16'h0000;
  localparam logic [DATA_W-1:0] EXT_STAT_VALUE = 16'h3000;
  localparam logic [IDLE_CNT_W-1:0] IDLE_CNT_MAX = 8'hff;

  // Controller register offsets on the AXI4-Lite side
  localparam int CSR_AW = 4;
  localparam logic [CSR_AW-1:0] CSR_CMD = 4'h0;
  localparam logic [CSR_AW-1:0] CSR_STATUS = 4'h4;
  localparam logic [CSR_AW-1:0] CSR_IRQ_STAT = 4'h8;
  localparam logic [CSR_AW-1:0] CSR_IRQ_MASK = 4'hc;

  // Controller field positions
  localparam int CMD_WRITE_BIT = 8;
  localparam int CMD_DATA_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_W = 1;

  // AXI responses
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage
